/* include/host_port_params.svh */
// Constants of the host-port pin-function block: field positions, reset values and widths.
// Included by the design and by the bench; it holds definitions only.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Interface-select level that picks the two-wire bus.
`define HP_SEL_I2C          1'b1
// Interrupt-enable register field positions.
`define HP_IER_RX_DATA      0
`define HP_IER_TX_SPACE     1
`define HP_IER_RX_ERROR     2
`define HP_IER_MODEM        3
`define HP_IER_GPIO         4
`define HP_IER_W            5
// Modem-control, enhanced-feature and io-control bit positions.
`define HP_MCR_RTS_BIT      1
`define HP_EFR_AUTO_RTS_BIT 6
`define HP_IOC_MODEM_BIT    1
// General I/O pins and the first pin that can carry a modem line.
`define HP_GPIO_W           8
`define HP_GPIO_MODEM_FIRST 4
// Reset values and widths.
`define HP_RTS_N_RESET      1'b1
`define HP_IRQ_N_LEVEL      1'b0
`define HP_BYTE_W           8
`define HP_BITCNT_W         3
`define HP_SYNC_W           3

`endif

/* include/host_port_pkg.sv */
// Types shared by the host-port pin-function block and its bench.
// Assumes host_port_params.svh is compiled alongside.
package host_port_pkg;

    // Modem lines carried by general I/O pins four to seven, all active low.
    typedef struct packed {
        logic ri_n;
        logic cd_n;
        logic dtr_n;
        logic dsr_n;
    } modem_lines_s;

    // Level interrupt sources in interrupt-enable order, bit 4 first.
    typedef struct packed {
        logic gpio_change;
        logic modem_flag;
        logic rx_error;
        logic tx_space;
        logic rx_data;
    } irq_src_s;

    typedef enum logic {
        PORT_SPI,
        PORT_I2C
    } port_mode_e;

endpackage

/* rtl/host_port_pin_function_select.sv */
// Pin-function logic of the host port of a serial bridge: mode select, SPI front end,
// two-wire pin handling, interrupt and request-to-send drivers, general I/O modem lines.
// Assumes the UART core, FIFOs and two-wire protocol engine sit outside on sys_clk_i,
// and that the host clock pin is the clock of the SPI front end.
//
// Operation
// - Interface-select high gives a two-wire bus slave, low gives an SPI slave.
// - In SPI mode the select pin is an active-low, hysteresis-filtered chip select.
// - In two-wire mode both shared pins give the low slave address bits.
// - In SPI mode serial host data enters on the shared data-in pin.
// - SPI mode drives the serial output three-state; two-wire mode leaves it unused.
// - One clock pin serves as two-wire clock and SPI clock by mode.
// - Two-wire mode drives data open-drain; SPI mode ignores the grounded data pin.
// - Interrupt pin pulls low only for sources enabled in the enable register.
// - Interrupts come from I/O changes, receive errors, data, space and modem flags.
// - Request-to-send goes low when the modem-control request bit is one and auto request-to-send is off.
// - Request-to-send is high after any reset.
// - Only auto request-to-send lets the line follow receive room.
// - Eight general I/O pins; pins four to seven may carry modem lines.
// - Io-control bit one picks general I/O or modem use of pins four to seven.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_params.svh"

module host_port_pin_function_select (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        serial_clk_i,
    input  wire logic                        iface_sel_i,
    input  wire logic                        select_or_addr_bit0_i,
    input  wire logic                        serial_in_or_addr_bit1_i,
    input  wire logic [`HP_BYTE_W-1:0]       spi_tx_byte_i,
    output logic                             so_o,
    output logic                             so_oe_o,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe_o,
    input  wire logic                        i2c_sda_pull_i,
    output logic                             i2c_scl_o,
    output logic                             i2c_sda_o,
    output logic [1:0]                       i2c_addr_bits_o,
    output logic                             i2c_mode_o,
    output logic                             spi_selected_o,
    output logic [`HP_BYTE_W-1:0]            spi_rx_byte_o,
    output logic                             spi_rx_valid_o,
    input  wire logic [`HP_IER_W-1:0]        interrupt_enable_reg_i,
    input  wire logic                        rx_data_avail_i,
    input  wire logic                        tx_space_avail_i,
    input  wire logic                        rx_error_i,
    input  wire logic                        cts_delta_i,
    input  wire logic                        gpio_status_read_i,
    input  wire logic                        modem_status_read_i,
    output logic                             irq_n_o,
    output logic                             irq_n_oe_o,
    input  wire logic [7:0]                  modem_control_reg_i,
    input  wire logic [7:0]                  enhanced_feature_reg_i,
    input  wire logic                        rx_room_i,
    output logic                             rts_n_o,
    input  wire logic [7:0]                  io_control_reg_i,
    input  wire logic [`HP_GPIO_W-1:0]       gpio_i,
    input  wire logic [`HP_GPIO_W-1:0]       gpio_out_i,
    input  wire logic [`HP_GPIO_W-1:0]       gpio_dir_i,
    input  wire logic                        dtr_req_i,
    output logic [`HP_GPIO_W-1:0]            gpio_o,
    output logic [`HP_GPIO_W-1:0]            gpio_oe_o,
    output logic [`HP_GPIO_W-1:0]            gpio_state_o,
    output host_port_pkg::modem_lines_s      modem_lines_o,
    output logic                             gpio_change_o,
    output logic                             modem_flag_o
);

    // ---------------------------------------------------------------- Pin synchronisers.
    // Every pin input passes three flops; a change counts once stages two and three agree.
    localparam int NSYNC = 4 + `HP_GPIO_W;

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] sync3_r;
    logic [NSYNC-1:0] pins_r;
    logic [NSYNC-1:0] pins_nxt;

    assign pins_raw = {gpio_i, sda_i, serial_clk_i, serial_in_or_addr_bit1_i, select_or_addr_bit0_i};

    genvar gs;
    generate
        for (gs = 0; gs < NSYNC; gs++) begin : g_sync
            // The filter holds its last value until two stages agree, which gives the
            // chip-select pin hysteresis against slow or noisy edges.
            assign pins_nxt[gs] = (sync2_r[gs] == sync3_r[gs]) ? sync3_r[gs] : pins_r[gs];
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // The select pin idles high; stages that start low would fake a select after reset.
            sync1_r <= {{(NSYNC-1){1'b0}}, 1'b1};
            sync2_r <= {{(NSYNC-1){1'b0}}, 1'b1};
            sync3_r <= {{(NSYNC-1){1'b0}}, 1'b1};
            pins_r  <= {{(NSYNC-1){1'b0}}, 1'b1};
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pins_r  <= pins_nxt;
        end
    end

    wire                  cs_n_f   = pins_r[0];
    wire                  si_f     = pins_r[1];
    wire                  scl_f    = pins_r[2];
    wire                  sda_f    = pins_r[3];
    wire [`HP_GPIO_W-1:0] gpio_f   = pins_r[NSYNC-1:4];

    // Interface select is a static strap; it is caught by three clocked flops after release.
    logic sel_s1_r;
    logic sel_s2_r;
    logic sel_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            sel_r    <= 1'b0;
        end else begin
            sel_s1_r <= iface_sel_i;
            sel_s2_r <= sel_s1_r;
            sel_r    <= sel_s2_r;
        end
    end

    wire i2c_mode = (sel_r == `HP_SEL_I2C);
    host_port_pkg::port_mode_e port_mode;
    assign port_mode = i2c_mode ? host_port_pkg::PORT_I2C : host_port_pkg::PORT_SPI;

    // ---------------------------------------------------------------- SPI front end, link clock.
    // The host clock stands still between frames, so the bit counter is cleared by the chip
    // select itself rather than by a clock edge that may never come.
    wire spi_pin_mode = (iface_sel_i != `HP_SEL_I2C);
    wire link_clr_n   = rst_n_i & spi_pin_mode & ~select_or_addr_bit0_i;

    logic [`HP_BITCNT_W-1:0] bit_cnt_r;
    logic [`HP_BYTE_W-1:0]   shift_in_r;
    logic [`HP_BYTE_W-1:0]   rx_hold_r;
    logic                    rx_tgl_r;
    logic                    so_bit_r;

    wire [`HP_BYTE_W-1:0] shift_in_nxt = {shift_in_r[`HP_BYTE_W-2:0], serial_in_or_addr_bit1_i};
    wire                  byte_done    = (bit_cnt_r == 3'h7);

    always_ff @(posedge serial_clk_i or negedge link_clr_n) begin
        if (!link_clr_n) begin
            bit_cnt_r  <= 3'h0;
            shift_in_r <= 8'h00;
        end else begin
            bit_cnt_r  <= bit_cnt_r + 3'h1;
            shift_in_r <= shift_in_nxt;
        end
    end

    // Received byte and its event toggle survive the end of the frame.
    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_hold_r <= 8'h00;
            rx_tgl_r  <= 1'b0;
        end else if (byte_done && link_clr_n) begin
            rx_hold_r <= shift_in_nxt;
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end

    // Mode 0: data changes on the falling edge. The transmit byte is quasi-static and must
    // be stable for a whole byte; the pin shows zero until the first fall, then bit six, so bit seven is never sent.
    wire [`HP_BITCNT_W-1:0] tx_idx = 3'h7 - bit_cnt_r;

    always_ff @(negedge serial_clk_i or negedge link_clr_n) begin
        if (!link_clr_n) begin
            so_bit_r <= 1'b0;
        end else begin
            so_bit_r <= spi_tx_byte_i[tx_idx];
        end
    end

    assign so_o = so_bit_r;

    // ---------------------------------------------------------------- Link to system crossing.
    logic [`HP_SYNC_W-1:0] tgl_sync_r;
    logic                  tgl_seen_r;
    logic [`HP_BYTE_W-1:0] rx_byte_r;
    logic                  rx_valid_r;

    wire tgl_stable = (tgl_sync_r[1] == tgl_sync_r[2]);
    wire rx_event   = tgl_stable && (tgl_sync_r[2] != tgl_seen_r);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_sync_r <= '0;
            tgl_seen_r <= 1'b0;
            rx_byte_r  <= 8'h00;
            rx_valid_r <= 1'b0;
        end else begin
            tgl_sync_r <= {tgl_sync_r[1:0], rx_tgl_r};
            tgl_seen_r <= rx_event ? tgl_sync_r[2] : tgl_seen_r;
            rx_byte_r  <= rx_event ? rx_hold_r : rx_byte_r;
            rx_valid_r <= rx_event && !i2c_mode;
        end
    end

    // ---------------------------------------------------------------- Host pin drivers.
    // The output enable trails the chip select by the filter delay; the host must allow
    // about five system clocks between select and the first clock edge.
    wire spi_sel      = !i2c_mode && !cs_n_f;
    wire so_oe_nxt    = spi_sel;
    wire sda_oe_nxt   = i2c_mode && i2c_sda_pull_i;
    wire [1:0] addr_nxt = i2c_mode ? {si_f, cs_n_f} : i2c_addr_bits_o;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_oe_o         <= 1'b0;
            sda_o           <= 1'b0;
            sda_oe_o        <= 1'b0;
            i2c_scl_o       <= 1'b1;
            i2c_sda_o       <= 1'b1;
            i2c_addr_bits_o <= 2'h0;
            i2c_mode_o      <= 1'b0;
            spi_selected_o  <= 1'b0;
        end else begin
            so_oe_o         <= so_oe_nxt;
            sda_o           <= 1'b0;
            sda_oe_o        <= sda_oe_nxt;
            i2c_scl_o       <= i2c_mode ? scl_f : 1'b1;
            i2c_sda_o       <= i2c_mode ? sda_f : 1'b1;
            i2c_addr_bits_o <= addr_nxt;
            i2c_mode_o      <= (port_mode == host_port_pkg::PORT_I2C);
            spi_selected_o  <= spi_sel;
        end
    end

    assign spi_rx_byte_o  = rx_byte_r;
    assign spi_rx_valid_o = rx_valid_r;

    // ---------------------------------------------------------------- General I/O and modem lines.
    wire modem_use = io_control_reg_i[`HP_IOC_MODEM_BIT];

    logic [`HP_GPIO_W-1:0] gpio_prev_r;
    logic [`HP_GPIO_W-1:0] pin_is_modem;
    logic [`HP_GPIO_W-1:0] pin_oe_nxt;
    logic [`HP_GPIO_W-1:0] pin_out_nxt;
    logic [`HP_GPIO_W-1:0] pin_change;

    genvar gp;
    generate
        for (gp = 0; gp < `HP_GPIO_W; gp++) begin : g_gpio
            assign pin_is_modem[gp] = modem_use && (gp >= `HP_GPIO_MODEM_FIRST);
            // Pin five is the terminal-ready output in modem use; pins four, six and seven are inputs.
            assign pin_oe_nxt[gp]  = pin_is_modem[gp] ? (gp == 5) : gpio_dir_i[gp];
            assign pin_out_nxt[gp] = (pin_is_modem[gp] && gp == 5) ? ~dtr_req_i : gpio_out_i[gp];
            assign pin_change[gp]  = (gpio_f[gp] != gpio_prev_r[gp]) && !pin_oe_nxt[gp];
        end
    endgenerate

    wire gpio_evt  = |(pin_change & ~pin_is_modem);
    wire modem_evt = |(pin_change & pin_is_modem) || cts_delta_i;

    logic                       gpio_flag_r;
    logic                       modem_flag_r;
    host_port_pkg::modem_lines_s modem_r;

    // A change in the same cycle as the status read keeps its flag: set wins over clear.
    wire gpio_flag_nxt  = gpio_evt  || (gpio_flag_r  && !gpio_status_read_i);
    wire modem_flag_nxt = modem_evt || (modem_flag_r && !modem_status_read_i);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_prev_r   <= '0;
            gpio_o        <= '0;
            gpio_oe_o     <= '0;
            gpio_state_o  <= '0;
            modem_r       <= '1;
            gpio_flag_r   <= 1'b0;
            modem_flag_r  <= 1'b0;
        end else begin
            gpio_prev_r   <= gpio_f;
            gpio_o        <= pin_out_nxt;
            gpio_oe_o     <= pin_oe_nxt;
            gpio_state_o  <= gpio_f;
            modem_r       <= modem_use ? {gpio_f[7], gpio_f[6], ~dtr_req_i, gpio_f[4]} : 4'hf;
            gpio_flag_r   <= gpio_flag_nxt;
            modem_flag_r  <= modem_flag_nxt;
        end
    end

    assign modem_lines_o = modem_r;
    assign gpio_change_o = gpio_flag_r;
    assign modem_flag_o  = modem_flag_r;

    // ---------------------------------------------------------------- Interrupt pin.
    host_port_pkg::irq_src_s irq_src;
    assign irq_src = '{gpio_change: gpio_flag_r,
                       modem_flag:  modem_flag_r,
                       rx_error:    rx_error_i,
                       tx_space:    tx_space_avail_i,
                       rx_data:     rx_data_avail_i};

    wire irq_active = |(irq_src & interrupt_enable_reg_i);

    // The pin is open drain: it only ever drives low, and the enable decides.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_n_o    <= `HP_IRQ_N_LEVEL;
            irq_n_oe_o <= 1'b0;
        end else begin
            irq_n_o    <= `HP_IRQ_N_LEVEL;
            irq_n_oe_o <= irq_active;
        end
    end

    // ---------------------------------------------------------------- Request to send.
    wire auto_rts = enhanced_feature_reg_i[`HP_EFR_AUTO_RTS_BIT];
    wire mcr_rts  = modem_control_reg_i[`HP_MCR_RTS_BIT];
    // Without auto flow control the line is a plain software output and carries no flow.
    wire rts_n_nxt = auto_rts ? ~rx_room_i : ~mcr_rts;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rts_n_o <= `HP_RTS_N_RESET;
        end else begin
            rts_n_o <= rts_n_nxt;
        end
    end

endmodule

`default_nettype wire

/* dv/host_port_pin_function_select_props.sv */
// Concurrent checks on the ports of the host-port pin-function block.
// Assumes pin inputs settle through the filters within seven system clocks.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_params.svh"

module host_port_pin_function_select_props (
    input wire logic                        sys_clk_i,
    input wire logic                        rst_n_i,
    input wire logic                        serial_clk_i,
    input wire logic                        iface_sel_i,
    input wire logic                        select_or_addr_bit0_i,
    input wire logic                        serial_in_or_addr_bit1_i,
    input wire logic                        so_oe_o,
    input wire logic                        sda_o,
    input wire logic                        sda_oe_o,
    input wire logic                        i2c_scl_o,
    input wire logic [1:0]                  i2c_addr_bits_o,
    input wire logic                        i2c_mode_o,
    input wire logic                        spi_selected_o,
    input wire logic                        spi_rx_valid_o,
    input wire logic [`HP_IER_W-1:0]        interrupt_enable_reg_i,
    input wire logic                        rx_data_avail_i,
    input wire logic                        tx_space_avail_i,
    input wire logic                        rx_error_i,
    input wire logic                        irq_n_oe_o,
    input wire logic                        gpio_change_o,
    input wire logic [7:0]                  modem_control_reg_i,
    input wire logic [7:0]                  enhanced_feature_reg_i,
    input wire logic                        rx_room_i,
    input wire logic                        rts_n_o,
    input wire logic [7:0]                  io_control_reg_i,
    input wire host_port_pkg::modem_lines_s modem_lines_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_RTS_MCR: assert property (!enhanced_feature_reg_i[6] |=> rts_n_o == !$past(modem_control_reg_i[1]))
        else $error("rts does not follow the modem-control request bit");
    AST_RTS_AUTO: assert property (enhanced_feature_reg_i[6] |=> rts_n_o == !$past(rx_room_i))
        else $error("auto rts does not follow receive room");
    // Reset itself is the cause here, so this one must not be disabled by it.
    AST_RTS_RESET: assert property (disable iff (1'b0) !rst_n_i |-> rts_n_o)
        else $error("rts low during reset");
    AST_IRQ_MASK: assert property (interrupt_enable_reg_i[4:3] == 2'b00 |=> irq_n_oe_o ==
        |($past({rx_error_i, tx_space_avail_i, rx_data_avail_i}) & $past(interrupt_enable_reg_i[2:0])))
        else $error("interrupt output does not match enabled level sources");
    AST_IRQ_GPIO: assert property (interrupt_enable_reg_i[4] && gpio_change_o |=> irq_n_oe_o)
        else $error("enabled pin-change flag does not pull the interrupt");
    AST_SO_FLOAT: assert property (select_or_addr_bit0_i [*7] |-> !so_oe_o && !spi_selected_o)
        else $error("serial output driven while select is inactive");
    AST_SPI_SEL: assert property ((!iface_sel_i && !select_or_addr_bit0_i) [*7] |-> spi_selected_o && so_oe_o)
        else $error("low select in SPI mode does not select the port");
    AST_SO_MODE: assert property (iface_sel_i [*7] |-> !so_oe_o && i2c_mode_o)
        else $error("serial output driven in two-wire mode");
    AST_SDA_OD: assert property (sda_oe_o |-> i2c_mode_o && !sda_o)
        else $error("data pin driven other than open-drain low");
    AST_ADDR: assert property ((iface_sel_i && $stable({serial_in_or_addr_bit1_i, select_or_addr_bit0_i})) [*8]
        |-> i2c_addr_bits_o == {serial_in_or_addr_bit1_i, select_or_addr_bit0_i})
        else $error("address bits do not follow the shared pins");
    AST_SCL: assert property ((iface_sel_i && $stable(serial_clk_i)) [*8] |-> i2c_scl_o == serial_clk_i)
        else $error("two-wire clock does not follow the clock pin");
    AST_RX_VALID: assert property (spi_rx_valid_o |-> !i2c_mode_o ##1 !spi_rx_valid_o)
        else $error("receive pulse in two-wire mode or longer than one cycle");
    AST_MODEM_OFF: assert property (!io_control_reg_i[1] [*2] |-> modem_lines_o == 4'hf)
        else $error("modem lines active while pins are general I/O");

    COV_SPI_BYTE: cover property (spi_rx_valid_o);
    COV_SDA_PULL: cover property (sda_oe_o);
    COV_GPIO_IRQ: cover property (gpio_change_o && irq_n_oe_o);
endmodule

bind host_port_pin_function_select host_port_pin_function_select_props u_props (.*);

`default_nettype wire

/* dv/spi_host_model.sv */
// Mode-0 SPI host standing on the far side of the block.
// Assumes an 80 ns link clock that stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // A frame shorter than eight bits is cut off by raising select early.
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        int k;
        cs_n_o = 1'b0;
        #400;
        for (k = 0; k < nbits; k++) begin
            si_o = tx[7-k];
            #40 sclk_o = 1'b1;
            rx = {rx[6:0], so_i};
            #40 sclk_o = 1'b0;
        end
        #300 cs_n_o = 1'b1;
        // The data line is not held after the frame, so it shows a changed level.
        si_o = ~si_o;
    endtask
endmodule

`default_nettype wire

/* dv/host_port_pin_function_select_tb_top.sv */
// Self-checking bench for the host-port pin-function block.
// Assumes the SPI host model on the link side and level stimulus for all other inputs.
`timescale 1ns/1ps
`default_nettype none

module host_port_pin_function_select_tb_top;
    logic       sys_clk_i, rst_n_i = 1'b1, iface_sel_i = 1'b0, i2c_sda_pull_i = 1'b0;
    logic       rx_data_avail_i = 1'b0, tx_space_avail_i = 1'b0, rx_error_i = 1'b0, cts_delta_i = 1'b0;
    logic       gpio_status_read_i = 1'b0, modem_status_read_i = 1'b0, rx_room_i = 1'b0, dtr_req_i = 1'b0;
    logic [7:0] spi_tx_byte_i = 8'h00, modem_control_reg_i = 8'h02, enhanced_feature_reg_i = 8'h00;
    logic [7:0] io_control_reg_i = 8'h00, gpio_i = 8'h00, gpio_out_i = 8'h00, gpio_dir_i = 8'h00;
    logic [4:0] interrupt_enable_reg_i = 5'h00;
    logic [1:0] addr_pins = 2'h0, i2c_addr_bits_o;
    logic       sclk_m, cs_m, si_m, so_o, so_oe_o, sda_o, sda_oe_o, i2c_scl_o, i2c_sda_o, i2c_mode_o;
    logic       spi_selected_o, spi_rx_valid_o, irq_n_o, irq_n_oe_o, rts_n_o, gpio_change_o, modem_flag_o;
    logic [7:0] spi_rx_byte_o, gpio_o, gpio_oe_o, gpio_state_o;
    logic [7:0] exp_q[$];
    int         n_errors = 0, comparisons = 0, seed = 31463;
    host_port_pkg::modem_lines_s modem_lines_o;
    wire        serial_clk_i = sclk_m;
    wire        select_or_addr_bit0_i = iface_sel_i ? addr_pins[0] : cs_m;
    wire        serial_in_or_addr_bit1_i = iface_sel_i ? addr_pins[1] : si_m;
    // Pull-up on the data line in two-wire mode; the board grounds it in SPI mode.
    wire        sda_i = iface_sel_i & !sda_oe_o;
    wire        so_pin = so_oe_o ? so_o : 1'bz;

    host_port_pin_function_select u_host_port_pin_function_select (.*);
    spi_host_model u_spi_host_model (.sclk_o(sclk_m), .cs_n_o(cs_m), .si_o(si_m), .so_i(so_pin));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    always @(negedge sys_clk_i) begin
        if (spi_rx_valid_o === 1'b1)
            check(spi_rx_byte_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial begin
        int         i;
        logic [7:0] b, t, r;
        // Reset falls after time zero so that its edge reaches every flop.
        #1 rst_n_i <= 1'b0;
        tick(16);
        check(rts_n_o, 1'b1);
        check(modem_lines_o, 4'hf);
        rst_n_i <= 1'b1;
        tick(8);
        check(rts_n_o, 1'b0);
        // The third frame is cut short and must yield no byte.
        for (i = 0; i < 6; i++) begin
            @(posedge sys_clk_i);
            b = 8'($random(seed));
            t = 8'($random(seed));
            spi_tx_byte_i <= t;
            if (i != 2)
                exp_q.push_back(b);
            #7.3;
            u_spi_host_model.xfer(b, (i == 2) ? 4 : 8, r);
            if (i != 2)
                check(r[6:0], t[6:0]);
            tick(8);
            check(so_oe_o, 1'b0);
        end
        check(exp_q.size() == 0, 1'b1);
        for (i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            enhanced_feature_reg_i <= {1'b0, i[2], 6'h00};
            modem_control_reg_i <= {6'h00, i[1], 1'b0};
            rx_room_i <= i[0];
            tick(3);
            check(rts_n_o, i[2] ? !i[0] : !i[1]);
        end
        @(posedge sys_clk_i);
        enhanced_feature_reg_i <= 8'h00;
        modem_control_reg_i <= 8'h02;
        rst_n_i <= 1'b0;
        tick(2);
        check(rts_n_o, 1'b1);
        rst_n_i <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk_i);
            t = 8'($random(seed));
            interrupt_enable_reg_i <= {2'b00, t[2:0]};
            {rx_error_i, tx_space_avail_i, rx_data_avail_i} <= t[5:3];
            tick(2);
            check(irq_n_oe_o, |(t[2:0] & t[5:3]));
        end
        interrupt_enable_reg_i <= 5'h18;
        {rx_error_i, tx_space_avail_i, rx_data_avail_i} <= 3'b000;
        cts_delta_i <= 1'b1;
        tick(1);
        cts_delta_i <= 1'b0;
        tick(2);
        check(modem_flag_o, 1'b1);
        check({irq_n_oe_o, irq_n_o}, 2'b10);
        modem_status_read_i <= 1'b1;
        tick(1);
        modem_status_read_i <= 1'b0;
        gpio_i <= 8'h01;
        tick(8);
        check(modem_flag_o, 1'b0);
        check(gpio_change_o, 1'b1);
        check(irq_n_oe_o, 1'b1);
        gpio_status_read_i <= 1'b1;
        tick(1);
        gpio_status_read_i <= 1'b0;
        tick(2);
        check(gpio_change_o, 1'b0);
        io_control_reg_i <= 8'h02;
        dtr_req_i <= 1'b1;
        gpio_i <= 8'h40;
        gpio_dir_i <= 8'h0f;
        gpio_out_i <= t;
        tick(8);
        check(modem_lines_o, 4'h4);
        check({gpio_oe_o[5], gpio_o[5]}, 2'b10);
        check(gpio_oe_o, 8'h2f);
        check(gpio_o[3:0], t[3:0]);
        check(gpio_state_o, 8'h40);
        iface_sel_i <= 1'b1;
        i2c_sda_pull_i <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            addr_pins <= i[1:0];
            tick(8);
            check(i2c_addr_bits_o, i[1:0]);
        end
        check(i2c_mode_o, 1'b1);
        check(so_oe_o, 1'b0);
        check({sda_oe_o, sda_o, i2c_sda_o, i2c_scl_o}, 4'h8);
        i2c_sda_pull_i <= 1'b0;
        u_spi_host_model.xfer(8'ha5, 8, r);
        tick(8);
        check({sda_oe_o, i2c_sda_o}, 2'b01);
        conclude();
    end
endmodule

`default_nettype wire
